// >>> dv/iifc_peer.sv
/* Other parties on the three wire pairs: pull-ups and a bus master.
 * Assumes the block pulls a line low while its enable is high. */
`timescale 1ns/100ps
module iifc_peer (
	// block side
	input  wire logic [2:0] scl_oe_i,
	input  wire logic [2:0] sda_oe_i,
	input  wire logic [2:0] scl_i,
	input  wire logic [2:0] sda_i,
	// wire levels
	output logic      [2:0] scl_o,
	output logic      [2:0] sda_o
);
	logic [2:0] sda_lo = 3'h0;
	// pull-ups: a released line reads high
	assign scl_o = ~(scl_oe_i & ~scl_i);
	assign sda_o = ~(sda_oe_i & ~sda_i | sda_lo);
	// start if stop is 0, else stop; clock left high throughout
	task cond(input logic stop);
		sda_lo = {3{stop}};
		#400;
		sda_lo = {3{~stop}};
		#400;
	endtask
	// too short for the filter to accept
	task glitch;
		sda_lo = ~sda_lo;
		#70;
		sda_lo = ~sda_lo;
	endtask
endmodule // iifc_peer

// >>> dv/iifc_sva.sv
/* Checker of the flag and bus-hold block, seeing only its ports.
 * Assumes a bind onto iifc_core from the bench top file. */
`timescale 1ns/100ps
module iifc_sva (
	// clock, reset, controls
	input wire logic                  CLK_I, RSTN_I, FLAG_POLICY_I,
	input wire logic                  FLAG_WR_I, BUF_WR_I, BUF_DONE_I,
	input wire logic [2:0]            PAIR_EN_I,
	input wire iifc_pkg::iifc_mode_t  OP_SELECT_I,
	input wire iifc_pkg::iifc_flags_t FLAG_WDATA_I, FLAGS_O,
	// status and pins
	input wire logic                  ARB_LOST_O, BUS_OCC_O, BUSY_O,
	input wire logic                  TRX_O, SCL_HOLD_O, DATA_REQ_O,
	input wire logic                  PROTO_REQ_O,
	input wire logic [2:0]            SCL_O, SCL_OE_O, SDA_O, SDA_OE_O,
	input wire logic [2:0]            BYTE_CNT_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);

	dreq_line_a: assert property (
		DATA_REQ_O == (FLAGS_O.data | FLAGS_O.endx))
		else $error("data request line wrong");
	preq_line_a: assert property (PROTO_REQ_O == FLAGS_O.proto)
		else $error("protocol request line wrong");
	hold_release_a: assert property (FLAGS_O == 3'h0 |-> !SCL_HOLD_O)
		else $error("clock held with no flag");
	hold_master_a: assert property (
		OP_SELECT_I == iifc_pkg::IIFC_MASTER && $stable(OP_SELECT_I)
		&& FLAGS_O != 3'h0 |-> SCL_HOLD_O)
		else $error("master not holding clock");
	pair_drive_a: assert property ($stable(PAIR_EN_I) |->
		SCL_OE_O == (PAIR_EN_I & {3{SCL_HOLD_O}}))
		else $error("clock enable wrong for pairs");
	pin_release_a: assert property (
		(SCL_OE_O & SCL_O) == 3'h0 && SDA_O == ~SDA_OE_O)
		else $error("line driven high");
	busy_occ_a: assert property (BUS_OCC_O |-> BUSY_O)
		else $error("occupied bus not busy");
	buf_dir_a: assert property (BUF_WR_I |=> TRX_O)
		else $error("buffer write left receive");
	flag_set_a: assert property (FLAG_WR_I |=>
		(FLAGS_O & $past(FLAG_WDATA_I)) == $past(FLAG_WDATA_I))
		else $error("software set lost");
	arb_proto_a: assert property ($rose(ARB_LOST_O) |-> ##[0:1]
		FLAGS_O.proto)
		else $error("arb loss without protocol flag");
	done_clear_a: assert property (
		BUF_DONE_I && !FLAG_POLICY_I && !FLAG_WR_I |=>
		!FLAGS_O.data && BYTE_CNT_O == 3'h0)
		else $error("buffer access kept data flag");
	sw_only_a: assert property (
		$fell(FLAGS_O.endx) || $fell(FLAGS_O.proto) |-> $past(FLAG_WR_I))
		else $error("flag cleared by hardware");
endmodule // iifc_sva

// >>> dv/iifc_tb.sv
/* Self-checking bench of the flag and bus-hold block.
 * Assumes checker and partner model are compiled before it. */
`timescale 1ns/100ps
module testbench;
	logic clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, pol = 1'b0, fwr = 1'b0;
	logic ack = 1'b0, mact = 1'b0, dval = 1'b0, sdal = 1'b0;
	logic [3:0] sw = 4'h0;
	logic [1:0] depth = 2'h0;
	logic [2:0] en = 3'h7, scl, sda, scl_o, scl_oe, sda_o, sda_oe, cnt;
	logic arb, lack, occ, busy, transmit_direction_bit, hold, dreq, preq;
	iifc_pkg::iifc_mode_t mode = iifc_pkg::IIFC_INIT;
	iifc_pkg::iifc_flags_t wdata = 3'h0, flags;
	iifc_pkg::iifc_ev_t ev = 4'h0;
	int mismatches = 0, num_checks = 0;
	always #20 clk = ~clk;
	initial #3 forever #6 lclk = ~lclk;
	iifc_core dut_u (.CLK_I(clk), .LINK_CLK_I(lclk), .RSTN_I(rst_n),
		.OP_SELECT_I(mode), .BUF_DEPTH_I(depth), .FLAG_POLICY_I(pol),
		.PAIR_EN_I(en), .FLAG_WR_I(fwr), .FLAG_WDATA_I(wdata),
		.ARB_CLR_I(sw[0]), .BUF_WR_I(sw[1]), .BUF_DONE_I(sw[2]),
		.DIR_WR_I(sw[3]), .DIR_VAL_I(dval), .LNK_EV_I(ev), .LNK_ACK_I(ack),
		.LNK_MASTER_ACT_I(mact), .LNK_SDA_LOW_I(sdal), .SCL_I(scl),
		.SDA_I(sda), .SCL_O(scl_o), .SCL_OE_O(scl_oe), .SDA_O(sda_o),
		.SDA_OE_O(sda_oe), .FLAGS_O(flags), .ARB_LOST_O(arb),
		.LAST_ACK_O(lack), .BUS_OCC_O(occ), .BUSY_O(busy), .TRX_O(transmit_direction_bit),
		.BYTE_CNT_O(cnt), .SCL_HOLD_O(hold), .DATA_REQ_O(dreq),
		.PROTO_REQ_O(preq));
	iifc_peer peer_u (.scl_oe_i(scl_oe), .sda_oe_i(sda_oe), .scl_i(scl_o),
		.sda_i(sda_o), .scl_o(scl), .sda_o(sda));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			mismatches++;
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// crossing takes 2..3 cycles, so 8 also keeps event spacing
	task lev(input int i, input logic a);
		@(posedge lclk);
		ev <= 4'h1 << i;
		ack <= a;
		@(posedge lclk);
		ev <= 4'h0;
		tick(8);
	endtask
	task swf(input iifc_pkg::iifc_flags_t v);
		@(posedge clk) fwr <= 1'b1;
		wdata <= v;
		@(posedge clk) fwr <= 1'b0;
		#1;
	endtask
	task pulse(input int b);
		@(posedge clk) sw[b] <= 1'b1;
		@(posedge clk) sw <= 4'h0;
		#1;
	endtask
	task t_init;
		chk({flags, busy, scl_oe}, 8'h00);
		chk({scl_o, sda_o}, 8'h3F);
		swf(3'h7);
		chk({flags, hold}, 8'h0E);
		swf(3'h0);
	endtask
	task t_depth;
		@(posedge clk) mode <= iifc_pkg::IIFC_MASTER;
		en <= 3'h5;
		for (int d = 0; d < 4; d++) begin
			@(posedge clk) depth <= d[1:0];
			for (int b = 0; b <= d; b++) begin
				chk({flags, cnt}, {3'h0, b[2:0]});
				lev(0, b[0]);
			end
			chk({dreq, preq, lack, cnt}, {2'h2, d[0], 3'h0});
			chk({hold, scl_oe, scl}, 7'h6A);
			swf(3'h0);
			chk({hold, scl_oe, scl_o}, 7'h07);
		end
	endtask
	task t_policy;
		@(posedge clk) depth <= 2'h0;
		for (int p = 0; p < 2; p++) begin
			@(posedge clk) pol <= p[0];
			lev(0, 1'b0);
			pulse(2);
			chk({flags, cnt}, {2'h0, p[0], 3'h0});
			swf(3'h0);
		end
		@(posedge clk) pol <= 1'b0;
		lev(1, 1'b0);
		pulse(2);
		chk({flags, dreq, preq}, 5'h0A);
		swf(3'h0);
	endtask
	task t_arb;
		@(posedge clk) mode <= iifc_pkg::IIFC_MULTI;
		@(posedge lclk) mact <= 1'b1;
		tick(8);
		chk(busy, 1'b1);
		lev(2, 1'b0);
		chk({arb, flags, preq, hold}, 6'h33);
		pulse(0);
		swf(3'h0);
		@(posedge lclk) mact <= 1'b0;
		tick(8);
		chk({arb, busy}, 2'h0);
	endtask
	task t_slave;
		@(posedge clk) mode <= iifc_pkg::IIFC_SLAVE;
		lev(3, 1'b0);
		chk({flags, hold}, 4'h9);
		swf(3'h0);
		pulse(1);
		chk(transmit_direction_bit, 1'b1);
		lev(1, 1'b0);
		chk(flags, 3'h3);
		swf(3'h0);
		pulse(3);
		chk(transmit_direction_bit, 1'b0);
		peer_u.cond(1'b0);
		tick(1);
		chk({occ, busy}, 2'h3);
		peer_u.glitch();
		tick(8);
		chk(occ, 1'b1);
		@(posedge lclk) sdal <= 1'b1;
		tick(4);
		chk({sda_oe, sda_o}, 6'h2A);
		@(posedge lclk) sdal <= 1'b0;
		tick(4);
		chk({sda_oe, sda_o}, 6'h07);
		peer_u.cond(1'b1);
		tick(1);
		chk(occ, 1'b0);
		swf(3'h1);
		chk(hold, 1'b0);
		swf(3'h0);
	endtask
	task report_and_stop;
		if (mismatches == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		tick(2);
		t_init;
		t_depth;
		t_policy;
		t_arb;
		t_slave;
		report_and_stop;
	end
	initial begin
		#200_000;
		mismatches++;
		report_and_stop;
	end
endmodule // testbench
bind iifc_core iifc_sva chk_u (.*);

// >>> logic/iifc_cfg.svh
/*
 * Constants of the two-wire flag and bus-hold block: mode codes, field
 * widths, reset values and filter timing.
 * Assumes inclusion by bare name from the package and the modules.
 */
`ifndef IIFC_CFG_SVH
`define IIFC_CFG_SVH

`define IIFC_PAIRS        3
`define IIFC_LINES        6
`define IIFC_FLT_SAMPLES  2'h3
`define IIFC_CNT_W        3

`define IIFC_MODE_INIT    2'h0
`define IIFC_MODE_SLAVE   2'h1
`define IIFC_MODE_MASTER  2'h2
`define IIFC_MODE_MULTI   2'h3

`define IIFC_FLAG_DATA    0
`define IIFC_FLAG_END     1
`define IIFC_FLAG_PROTO   2

`define IIFC_EV_BYTE      0
`define IIFC_EV_END       1
`define IIFC_EV_ARB       2
`define IIFC_EV_ADDR      3

`define IIFC_RST_LINES    6'h3F
`define IIFC_RST_FLAGS    3'h0

`endif

// >>> logic/iifc_core.sv
/*
 * Flag, clock-hold and bus-state logic of a two-wire serial controller:
 * request flags, bus-occupied tracking, pin-pair selection, input filters.
 * Assumes a bus sequencer on LINK_CLK_I reporting byte, end, arbitration
 * and address events, and software driving the control ports on CLK_I.
 * Link events of one kind come at least four CLK_I cycles apart, and
 * LNK_ACK_I stays stable from its byte event until the next one.
 * Pin inputs are asynchronous and pass two flops before the filter.
 * Outputs are registered except the request lines and BUSY_O.
 */
`timescale 1ns/100ps
`include "iifc_cfg.svh"

// What this block does
// - Master counts busy while the master-active flag stays set.
// - Bus-occupied flag set by start or repeated start, cleared by stop.
// - In initialization mode all registers are freely accessible.
// - Last-ack bit keeps acknowledge of final byte before latest request raised while master.
// - Data and end flags drive one request line, protocol flag another.
// - Any flag set while master or addressed slave holds clock low.
// - Software may set and clear the request flags to stall the bus.
// - Data flag set when configured number of buffer bytes transferred.
// - Slave transmitter cut short sets data flag besides end flag.
// - Policy bit 0: buffer access clears data flag; 1: software only.
// - End flag set on repeated start, stop or missing acknowledge.
// - Lost arbitration in multi-master sets protocol and arb-lost flags.
// - Own or general call address sets protocol flag in slave modes.
// - Up to three clock/data pin pairs, each with its own enable.
// - Lines released by turning the driver off; low driven only to assert low.
// - Clock and data inputs always noise filtered; only enabled pairs feed the bus level.
// - Buffer depth selectable as one to four bytes.
// - Writing the transfer buffer sets transmit direction.
module iifc_core (
	// clocks and reset
	input  wire logic                CLK_I,
	input  wire logic                LINK_CLK_I,
	input  wire logic                RSTN_I,
	// configuration
	input  wire iifc_pkg::iifc_mode_t OP_SELECT_I,
	input  wire logic [1:0]          BUF_DEPTH_I,
	input  wire logic                FLAG_POLICY_I,
	input  wire logic [2:0]          PAIR_EN_I,
	// software accesses
	input  wire logic                FLAG_WR_I,
	input  wire iifc_pkg::iifc_flags_t FLAG_WDATA_I,
	input  wire logic                ARB_CLR_I,
	input  wire logic                BUF_WR_I,
	input  wire logic                BUF_DONE_I,
	input  wire logic                DIR_WR_I,
	input  wire logic                DIR_VAL_I,
	// sequencer, link clock domain
	input  wire iifc_pkg::iifc_ev_t  LNK_EV_I,
	input  wire logic                LNK_ACK_I,
	input  wire logic                LNK_MASTER_ACT_I,
	input  wire logic                LNK_SDA_LOW_I,
	// bus pins
	input  wire logic [2:0]          SCL_I,
	input  wire logic [2:0]          SDA_I,
	output logic [2:0]               SCL_O,
	output logic [2:0]               SCL_OE_O,
	output logic [2:0]               SDA_O,
	output logic [2:0]               SDA_OE_O,
	// status
	output iifc_pkg::iifc_flags_t    FLAGS_O,
	output logic                     ARB_LOST_O,
	output logic                     LAST_ACK_O,
	output logic                     BUS_OCC_O,
	output logic                     BUSY_O,
	output logic                     TRX_O,
	output logic [2:0]               BYTE_CNT_O,
	output logic                     SCL_HOLD_O,
	// requests
	output logic                     DATA_REQ_O,
	output logic                     PROTO_REQ_O
);

	iifc_pkg::iifc_state_t q_q;
	iifc_pkg::iifc_state_t d_d;
	iifc_pkg::iifc_link_t  link_w;

	// bus line seen by the block: wired-AND of the enabled pairs
	function automatic logic bus_level(input logic [5:0] flt,
		input logic [2:0] en, input int unsigned ofs);
		logic lvl;
		lvl = 1'b1;
		for (int p = 0; p < `IIFC_PAIRS; p++) begin
			if (en[p]) begin
				lvl = lvl & flt[2 * p + ofs];
			end
		end
		return lvl;
	endfunction

	// mode decodes shared by several rules
	function automatic logic mode_is_multi(input iifc_pkg::iifc_mode_t m);
		return m == iifc_pkg::IIFC_MULTI;
	endfunction

	function automatic logic mode_takes_addr(
		input iifc_pkg::iifc_mode_t m);
		return (m == iifc_pkg::IIFC_SLAVE) ||
			(m == iifc_pkg::IIFC_MULTI);
	endfunction

	// master mode, or the active master of a multi-master bus
	function automatic logic mode_is_master(input iifc_pkg::iifc_mode_t m,
		input logic act);
		return (m == iifc_pkg::IIFC_MASTER) ||
			((m == iifc_pkg::IIFC_MULTI) && act);
	endfunction

	// one line of the stability filter: new level and sample count;
	// a pulse shorter than three samples never reaches the level
	function automatic logic [2:0] filt_step(input logic raw,
		input logic lvl, input logic [1:0] cnt);
		logic [2:0] r;
		if (raw == lvl) begin
			r = {lvl, 2'h0};
		end else if (cnt == `IIFC_FLT_SAMPLES - 2'h1) begin
			r = {raw, 2'h0};
		end else begin
			r = {lvl, cnt + 2'h1};
		end
		return r;
	endfunction

	// pull the enabled pairs low; disabled pairs stay released
	function automatic logic [2:0] pair_drive(input logic [2:0] en,
		input logic on);
		return en & {3{on}};
	endfunction

	// only toggles and a held ack level leave the link encoder
	iifc_link u_link (
		.link_clk_i (LINK_CLK_I),
		.rst_n_i    (RSTN_I),
		.ev_i       (LNK_EV_I),
		.ack_i      (LNK_ACK_I),
		.link_o     (link_w)
	);

	logic                  scl_bus;
	logic                  sda_bus;
	logic                  start_c;
	logic                  stop_c;
	logic                  is_master;
	iifc_pkg::iifc_ev_t    ev;
	iifc_pkg::iifc_flags_t hw_set;
	logic [2:0]            depth;
	logic [5:0]            pins;
	logic                  arb_hit;
	logic                  addr_hit;
	logic                  cut_short;

	// pairs gathered into one vector: clock at even, data at odd index
	for (genvar g = 0; g < `IIFC_PAIRS; g++) begin : g_pins
		assign pins[2 * g] = SCL_I[g];
		assign pins[2 * g + 1] = SDA_I[g];
	end

	always_comb begin
		d_d = q_q;
		hw_set = '0;
		depth = {1'b0, BUF_DEPTH_I} + 3'h1;

		// two-flop sync, then the stability filter on every line
		d_d.sync1 = pins;
		d_d.sync2 = q_q.sync1;
		for (int i = 0; i < `IIFC_LINES; i++) begin
			{d_d.flt[i], d_d.flt_cnt[2 * i +: 2]} = filt_step(
				q_q.sync2[i], q_q.flt[i], q_q.flt_cnt[2 * i +: 2]);
		end

		scl_bus = bus_level(q_q.flt, PAIR_EN_I, 0);
		sda_bus = bus_level(q_q.flt, PAIR_EN_I, 1);
		d_d.scl_prev = scl_bus;
		d_d.sda_prev = sda_bus;
		start_c = scl_bus & q_q.scl_prev & q_q.sda_prev & ~sda_bus;
		stop_c = scl_bus & q_q.scl_prev & ~q_q.sda_prev & sda_bus;
		if (start_c) begin
			d_d.bus_occ = 1'b1;
		end else if (stop_c) begin
			d_d.bus_occ = 1'b0;
		end

		// event toggles and levels from the link domain
		// a toggle survives any clock ratio, where a short pulse could slip
		d_d.tog_s1 = link_w.tog;
		d_d.tog_s2 = q_q.tog_s1;
		d_d.tog_s3 = q_q.tog_s2;
		ev = q_q.tog_s2 ^ q_q.tog_s3;
		d_d.mact_s1 = LNK_MASTER_ACT_I;
		d_d.mact_s2 = q_q.mact_s1;
		d_d.sdal_s1 = LNK_SDA_LOW_I;
		d_d.sdal_s2 = q_q.sdal_s1;
		is_master = mode_is_master(OP_SELECT_I, q_q.mact_s2);

		// byte counting against the selected depth
		if (BUF_DONE_I) begin
			d_d.byte_cnt = 3'h0;
		end
		if (ev.byte_done) begin
			// link ack is stable by the time its toggle has resynced
			d_d.ack_sh = link_w.ack;
			if (q_q.byte_cnt + 3'h1 >= depth) begin
				hw_set.data = 1'b1;
				d_d.byte_cnt = 3'h0;
			end else begin
				d_d.byte_cnt = q_q.byte_cnt + 3'h1;
			end
		end
		// cut_short: slave transmitter ended before its buffer ran out
		arb_hit = ev.arb && mode_is_multi(OP_SELECT_I);
		addr_hit = ev.addr && mode_takes_addr(OP_SELECT_I);
		cut_short = ev.endx && q_q.transmit_direction_bit && !is_master && q_q.addressed;
		if (ev.endx) begin
			hw_set.endx = 1'b1;
		end
		if (cut_short) begin
			hw_set.data = 1'b1;
		end
		if (arb_hit) begin
			hw_set.proto = 1'b1;
		end
		if (addr_hit) begin
			hw_set.proto = 1'b1;
		end

		// addressed slave until the next start or stop; a match wins
		if (start_c || stop_c) begin
			d_d.addressed = 1'b0;
		end
		if (addr_hit) begin
			d_d.addressed = 1'b1;
		end

		// software first, hardware sets last so a set is never lost
		if (FLAG_WR_I) begin
			d_d.flags = FLAG_WDATA_I;
		end
		if (BUF_DONE_I && !FLAG_POLICY_I) begin
			d_d.flags.data = 1'b0;
		end
		d_d.flags = d_d.flags | hw_set;
		if (ARB_CLR_I) begin
			d_d.arb_lost = 1'b0;
		end
		if (arb_hit) begin
			d_d.arb_lost = 1'b1;
		end
		if (hw_set != '0 && is_master) begin
			d_d.last_ack = ev.byte_done ? link_w.ack : q_q.ack_sh;
		end

		// direction: buffer write forces transmit
		if (BUF_WR_I) begin
			d_d.transmit_direction_bit = 1'b1;
		end else if (DIR_WR_I) begin
			d_d.transmit_direction_bit = DIR_VAL_I;
		end

		// hold follows next flags so release comes in the same cycle as the clear
		d_d.hold = (|d_d.flags) && (is_master || d_d.addressed);
		d_d.scl_oe = pair_drive(PAIR_EN_I, d_d.hold);
		d_d.sda_oe = pair_drive(PAIR_EN_I, q_q.sdal_s2);
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			q_q <= '0;
			// lines and edge history reset to the idle high level, so
			// no false start or stop follows reset
			q_q.sync1 <= `IIFC_RST_LINES;
			q_q.sync2 <= `IIFC_RST_LINES;
			q_q.flt <= `IIFC_RST_LINES;
			q_q.scl_prev <= 1'b1;
			q_q.sda_prev <= 1'b1;
			q_q.flags <= `IIFC_RST_FLAGS;
		end else begin
			q_q <= d_d;
		end
	end

	// open drain: value is low while enabled; released data is high, released clock high only while hold is clear
	assign SCL_O = {3{~q_q.hold}};
	assign SCL_OE_O = q_q.scl_oe;
	assign SDA_O = ~q_q.sda_oe;
	assign SDA_OE_O = q_q.sda_oe;
	// status straight from state; request lines are plain ors
	assign FLAGS_O = q_q.flags;
	assign ARB_LOST_O = q_q.arb_lost;
	assign LAST_ACK_O = q_q.last_ack;
	assign BUS_OCC_O = q_q.bus_occ;
	assign BUSY_O = q_q.mact_s2 | q_q.bus_occ;
	assign TRX_O = q_q.transmit_direction_bit;
	assign BYTE_CNT_O = q_q.byte_cnt;
	assign SCL_HOLD_O = q_q.hold;
	assign DATA_REQ_O = q_q.flags.data | q_q.flags.endx;
	assign PROTO_REQ_O = q_q.flags.proto;

endmodule // iifc_core

// >>> logic/iifc_link.sv
/*
 * Link-domain event encoder: turns one-cycle event pulses of the bus
 * sequencer into toggles and holds the acknowledge level of each byte.
 * Assumes the sequencer runs on link_clk_i and the consumer resyncs.
 */
`timescale 1ns/100ps
`include "iifc_cfg.svh"

module iifc_link (
	// link clock and reset
	input  wire logic              link_clk_i,
	input  wire logic              rst_n_i,
	// sequencer events
	input  wire iifc_pkg::iifc_ev_t ev_i,
	input  wire logic              ack_i,
	// toward the peripheral clock domain
	output iifc_pkg::iifc_link_t   link_o
);

	iifc_pkg::iifc_link_t q_q;
	iifc_pkg::iifc_link_t d_d;

	always_comb begin
		d_d = q_q;
		d_d.tog = q_q.tog ^ ev_i;
		// ack is held until the next byte, long past the resync of its toggle
		if (ev_i.byte_done) begin
			d_d.ack = ack_i;
		end
	end

	always_ff @(posedge link_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q_q <= '0;
		end else begin
			q_q <= d_d;
		end
	end

	assign link_o = q_q;

endmodule // iifc_link

// >>> logic/iifc_pkg.sv
/*
 * Types of the two-wire flag and bus-hold block.
 * Assumes iifc_cfg.svh is on the include path.
 */
`include "iifc_cfg.svh"

package iifc_pkg;

	typedef enum logic [1:0] {
		IIFC_INIT   = 2'h0,
		IIFC_SLAVE  = 2'h1,
		IIFC_MASTER = 2'h2,
		IIFC_MULTI  = 2'h3
	} iifc_mode_t;

	typedef struct packed {
		logic proto;
		logic endx;
		logic data;
	} iifc_flags_t;

	typedef struct packed {
		logic addr;
		logic arb;
		logic endx;
		logic byte_done;
	} iifc_ev_t;

	typedef struct packed {
		iifc_ev_t tog;
		logic     ack;
	} iifc_link_t;

	typedef struct packed {
		logic [5:0]  sync1;
		logic [5:0]  sync2;
		logic [5:0]  flt;
		logic [11:0] flt_cnt;
		logic        scl_prev;
		logic        sda_prev;
		iifc_ev_t    tog_s1;
		iifc_ev_t    tog_s2;
		iifc_ev_t    tog_s3;
		logic        ack_s;
		logic        mact_s1;
		logic        mact_s2;
		logic        sdal_s1;
		logic        sdal_s2;
		iifc_flags_t flags;
		logic        arb_lost;
		logic        last_ack;
		logic        ack_sh;
		logic        bus_occ;
		logic        addressed;
		logic        transmit_direction_bit;
		logic [2:0]  byte_cnt;
		logic        hold;
		logic [2:0]  scl_oe;
		logic [2:0]  sda_oe;
	} iifc_state_t;

endpackage
